// ### core/bmd_matrix.sv
// address decode, path check, boot remap and sram split for the matrix
`timescale 1ns/1ps
module bmd_matrix (
	input wire logic clk,
	input wire logic nrst,
	input wire logic boot_source_select_pin,
	input wire logic [5:0] m_req,
	input wire logic [5:0][31:0] m_addr,
	output logic [5:0] m_ready,
	output logic [5:0] m_err,
	input wire logic [5:0] per_master_remap_set,
	input wire logic [5:0] per_master_remap_clr,
	input wire logic coupled_ram_size_wr,
	input wire logic [1:0] instruction_coupled_ram_area,
	input wire logic [1:0] data_coupled_ram_area,
	output logic [5:0] per_master_remap_bit,
	output logic [1:0] instr_units,
	output logic [1:0] data_units,
	output logic boot_from_rom,
	output logic [5:0] s_valid,
	output logic [5:0][2:0] s_master,
	output logic [5:0][31:0] s_addr,
	output logic [1:0] sram_block,
	output logic [2:0] external_chip_select_zero_idx
);
	// ======================================================================
	// state
	typedef struct packed {
		logic pin_meta;
		logic pin_sync;
		logic [1:0] settle;
		logic boot_rom;
		logic [5:0] remap;
		logic [1:0] isz;
		logic [1:0] dsz;
		logic [5:0] s_valid;
		logic [5:0][2:0] s_master;
		logic [5:0][31:0] s_addr;
		logic [1:0] sram_block;
		logic [2:0] ebi_cs;
		logic [5:0] m_err;
	} bmd_state_s;

	bmd_state_s st;
	bmd_state_s next_st;
	bmd_pkg::bmd_dec_s dec [6];
	logic [5:0][5:0] sreq;
	logic [5:0][5:0] sgnt;

	// ======================================================================
	// block lent to a coupled area: instr takes 1 then 0, data 3 then 2
	function automatic logic block_taken(
		input logic [1:0] b,
		input logic [1:0] isz,
		input logic [1:0] dsz
	);
		logic taken;
		taken = 1'b0;
		case (b)
			bmd_pkg::BLK_ONE: taken = isz != 2'h0;
			bmd_pkg::BLK_ZERO: taken = isz == bmd_pkg::TCM_MAX_UNITS;
			bmd_pkg::BLK_THREE: taken = dsz != 2'h0;
			bmd_pkg::BLK_TWO: taken = dsz == bmd_pkg::TCM_MAX_UNITS;
			default: taken = 1'b0;
		endcase
		return taken;
	endfunction

	// ======================================================================
	// block that serves unit u of the general sram area
	function automatic logic [1:0] sram_c_block(
		input logic [5:0] u,
		input logic [1:0] isz,
		input logic [1:0] dsz
	);
		logic [5:0] cnt;
		logic [1:0] b;
		logic [1:0] res;

		cnt = 6'h00;
		res = bmd_pkg::BLK_ZERO;
		for (int k = 3; k >= 0; k--) begin
			b = 2'(k);
			// blocks go out in descending order
			if (!block_taken(b, isz, dsz)) begin
				if (cnt == u)
					res = b;
				cnt = cnt + 6'h01;
			end
		end
		return res;
	endfunction

	// ======================================================================
	// boot window: remapped sram, else rom or external memory by boot pin
	function automatic bmd_pkg::bmd_dec_s boot_decode(
		input bmd_pkg::bmd_dec_s d_in,
		input logic [19:0] off,
		input logic remap,
		input logic boot_rom,
		input logic [1:0] isz,
		input logic [1:0] dsz
	);
		bmd_pkg::bmd_dec_s d;
		logic [5:0] unit;
		logic [5:0] c_units;

		d = d_in;
		unit = off[19:14];
		c_units = bmd_pkg::SRAM_UNITS - 6'(isz) - 6'(dsz);
		if (remap) begin
			d.slave = bmd_pkg::SLV_SRAM;
			d.err = unit >= c_units;
			d.block = sram_c_block(unit, isz, dsz);
		end else if (boot_rom) begin
			d.slave = bmd_pkg::SLV_ROM;
			d.err = off >= bmd_pkg::ROM_SIZE;
		end else begin
			d.slave = bmd_pkg::SLV_EBI;
			d.err = 1'b0;
			d.cs = 3'h0;
		end
		return d;
	endfunction

	// ======================================================================
	// coupled ram seen from the bus; the instruction port is shut out
	function automatic bmd_pkg::bmd_dec_s tcm_decode(
		input bmd_pkg::bmd_dec_s d_in,
		input logic [2:0] m,
		input logic [5:0] unit,
		input logic [1:0] size,
		input logic [1:0] first,
		input logic [1:0] second
	);
		bmd_pkg::bmd_dec_s d;

		d = d_in;
		d.slave = bmd_pkg::SLV_SRAM;
		d.err = unit >= 6'(size) || m == bmd_pkg::M_CPU_INSTR;
		d.block = (unit == 6'h00) ? first : second;
		return d;
	endfunction

	// ======================================================================
	// chip select of an external bank; upper banks share the last one
	function automatic logic [2:0] ebi_select(
		input logic [3:0] bank
	);
		logic [3:0] rel;

		rel = bank - bmd_pkg::BANK_EBI_FIRST;
		if (rel > 4'(bmd_pkg::EBI_CS_MAX))
			rel = 4'(bmd_pkg::EBI_CS_MAX);
		return rel[2:0];
	endfunction

	// ======================================================================
	// one master's decoder; every master calls the same map
	function automatic bmd_pkg::bmd_dec_s decode(
		input logic [2:0] m,
		input logic [31:0] a,
		input logic remap,
		input logic boot_rom,
		input logic [1:0] isz,
		input logic [1:0] dsz
	);
		bmd_pkg::bmd_dec_s d;
		logic [7:0] region;
		logic [5:0] unit;
		logic [5:0] c_units;

		d = '0;
		d.err = 1'b1;
		d.addr = a;
		region = a[27:20];
		unit = a[19:14];
		c_units = bmd_pkg::SRAM_UNITS - 6'(isz) - 6'(dsz);
		if (a[31:28] == bmd_pkg::BANK_INTERNAL) begin
			d.addr = {12'h000, a[19:0]};
			case (region)
				bmd_pkg::REG_BOOT: begin
					d = boot_decode(d, a[19:0], remap, boot_rom, isz,
						dsz);
				end
				bmd_pkg::REG_INSTRUCTION_COUPLED_RAM_AREA: begin
					d = tcm_decode(d, m, unit, isz, bmd_pkg::BLK_ONE,
						bmd_pkg::BLK_ZERO);
				end
				bmd_pkg::REG_DATA_COUPLED_RAM_AREA: begin
					d = tcm_decode(d, m, unit, dsz, bmd_pkg::BLK_THREE,
						bmd_pkg::BLK_TWO);
				end
				bmd_pkg::REG_SRAMC: begin
					d.slave = bmd_pkg::SLV_SRAM;
					d.err = unit >= c_units;
					d.block = sram_c_block(unit, isz, dsz);
				end
				bmd_pkg::REG_ROM: begin
					d.slave = bmd_pkg::SLV_ROM;
					d.err = a[19:0] >= bmd_pkg::ROM_SIZE;
				end
				bmd_pkg::REG_LCD: begin
					d.slave = bmd_pkg::SLV_LCD;
					d.err = 1'b0;
				end
				bmd_pkg::REG_UDP: begin
					d.slave = bmd_pkg::SLV_UDP;
					d.err = 1'b0;
				end
				default: begin
					d.err = 1'b1;
				end
			endcase
		end else if (a[31:28] >= bmd_pkg::BANK_EBI_FIRST &&
			a[31:28] <= bmd_pkg::BANK_EBI_LAST) begin
			d.slave = bmd_pkg::SLV_EBI;
			d.err = 1'b0;
			d.cs = ebi_select(a[31:28]);
		end else if (a[31:28] == bmd_pkg::BANK_PERIPH) begin
			d.slave = bmd_pkg::SLV_BRIDGE;
			d.err = 1'b0;
		end
		// unwired paths answer like an unmapped hole
		if (!d.err && !bmd_pkg::PATH[d.slave][m])
			d.err = 1'b1;
		return d;
	endfunction

	// ======================================================================
	// decoders and request routing
	always_comb begin
		for (int m = 0; m < bmd_pkg::NUM_M; m++) begin
			dec[m] = decode(3'(m), m_addr[m], st.remap[m], st.boot_rom,
				st.isz, st.dsz);
		end
		for (int s = 0; s < bmd_pkg::NUM_S; s++) begin
			for (int m = 0; m < bmd_pkg::NUM_M; m++) begin
				sreq[s][m] = m_req[m] && !dec[m].err &&
					dec[m].slave == 3'(s);
			end
		end
	end

	// ======================================================================
	// per slave arbiters
	genvar gs;
	generate
		for (gs = 0; gs < bmd_pkg::NUM_S; gs++) begin : g_arb
			bmd_arb #(
				.FIXED(bmd_pkg::ARB_FIXED[gs])
			) bmd_arb_i (
				.clk(clk),
				.nrst(nrst),
				.req(sreq[gs]),
				.gnt(sgnt[gs])
			);
		end
	endgenerate

	always_comb begin
		logic [5:0] any_gnt;
		any_gnt = 6'h00;
		for (int s = 0; s < bmd_pkg::NUM_S; s++)
			any_gnt = any_gnt | sgnt[s];
		// errors never wait on an arbiter
		m_ready = m_req & (any_gnt | {dec[5].err, dec[4].err, dec[3].err,
			dec[2].err, dec[1].err, dec[0].err});
	end

	// ======================================================================
	// next state
	always_comb begin
		next_st = st;
		// boot pin: two flops, then caught once after reset release
		next_st.pin_meta = boot_source_select_pin;
		next_st.pin_sync = st.pin_meta;
		if (st.settle != bmd_pkg::BOOT_SETTLE) begin
			next_st.settle = st.settle + 2'h1;
			if (st.settle + 2'h1 == bmd_pkg::BOOT_SETTLE)
				next_st.boot_rom = st.pin_sync;
		end
		// set wins over clear in the same cycle
		next_st.remap = ((st.remap & ~per_master_remap_clr) |
			per_master_remap_set) & bmd_pkg::REMAP_CAPABLE;
		// illegal sizes leave the split untouched
		if (coupled_ram_size_wr &&
			instruction_coupled_ram_area <= bmd_pkg::TCM_MAX_UNITS &&
			data_coupled_ram_area <= bmd_pkg::TCM_MAX_UNITS) begin
			next_st.isz = instruction_coupled_ram_area;
			next_st.dsz = data_coupled_ram_area;
		end
		// address phase taken here; answers stand one cycle later
		next_st.m_err = 6'h00;
		for (int m = 0; m < bmd_pkg::NUM_M; m++)
			next_st.m_err[m] = m_req[m] && dec[m].err;
		for (int s = 0; s < bmd_pkg::NUM_S; s++) begin
			next_st.s_valid[s] = |sgnt[s];
			next_st.s_master[s] = 3'h0;
			next_st.s_addr[s] = 32'h0000_0000;
			for (int m = 0; m < bmd_pkg::NUM_M; m++) begin
				if (sgnt[s][m]) begin
					next_st.s_master[s] = 3'(m);
					next_st.s_addr[s] = dec[m].addr;
					if (3'(s) == bmd_pkg::SLV_SRAM)
						next_st.sram_block = dec[m].block;
					if (3'(s) == bmd_pkg::SLV_EBI)
						next_st.ebi_cs = dec[m].cs;
				end
			end
		end
	end

	// ======================================================================
	// registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st.pin_meta <= 1'b0;
			st.pin_sync <= 1'b0;
			st.settle <= 2'h0;
			st.boot_rom <= bmd_pkg::BOOT_ROM_RESET;
			st.remap <= 6'h00;
			st.isz <= bmd_pkg::TCM_RESET;
			st.dsz <= bmd_pkg::TCM_RESET;
			st.s_valid <= 6'h00;
			st.s_master <= '0;
			st.s_addr <= '0;
			st.sram_block <= 2'h0;
			st.ebi_cs <= 3'h0;
			st.m_err <= 6'h00;
		end else begin
			st <= next_st;
		end
	end

	// ======================================================================
	// outputs
	assign m_err = st.m_err;
	assign per_master_remap_bit = st.remap;
	assign instr_units = st.isz;
	assign data_units = st.dsz;
	assign boot_from_rom = st.boot_rom;
	assign s_valid = st.s_valid;
	assign s_master = st.s_master;
	assign s_addr = st.s_addr;
	assign sram_block = st.sram_block;
	assign external_chip_select_zero_idx = st.ebi_cs;
endmodule

// ### common/bmd_pkg.sv
// constants and types for the bus matrix decoder and boot remap
// ==========================================================================
// Summary of operation
// - six masters, each with its own decoder, all using the same map.
// - six slaves, each with its own arbiter, scheme chosen per slave.
// - every master reaches every slave except on unconnected paths.
// - slaves 2 and 3 only for masters 4 and 5; master 2 never ROM.
// - upper four address bits pick one of sixteen 256 MB banks.
// - banks 1 to 8 go to external bus, chip selects zero to five.
// - bank 0 holds internal memories, 1 MB regions by second decode.
// - bank 15 goes to the peripheral bridge.
// - any unmapped address gives an error answer to the master.
// - address zero: ROM or chip select zero by boot pin, SRAM if remapped.
// - boot pin caught at reset; high picks ROM, low external memory.
// - region 0x0 to 0x000FFFFF is the boot window that remap acts on.
// - general SRAM at 0x00300000; after remap also at zero, CPU only.
// - ROM always decodes at 0x00400000.
// - instruction coupled area at 0x00100000 for DMA and data master.
// - data coupled area at 0x00200000 for DMA and data master.
// - 64 KB split in 16 KB units; coupled areas 0, 16K or 32K each.
// - after reset all four blocks belong to the general area.
// - instr uses block 1 then 0, data 3 then 2, general the rest.
// - internal SRAM access completes in one master clock cycle.
package bmd_pkg;
	// ======================================================================
	// matrix shape
	localparam int NUM_M = 6;
	localparam int NUM_S = 6;
	localparam logic [2:0] SLV_ROM = 3'h0;
	localparam logic [2:0] SLV_SRAM = 3'h1;
	localparam logic [2:0] SLV_LCD = 3'h2;
	localparam logic [2:0] SLV_UDP = 3'h3;
	localparam logic [2:0] SLV_EBI = 3'h4;
	localparam logic [2:0] SLV_BRIDGE = 3'h5;
	// bit m of entry s set when master m is wired to slave s
	localparam logic [5:0][5:0] PATH = {
		6'h07, 6'h3F, 6'h30, 6'h30, 6'h3F, 6'h3B};
	// masters whose remap bit can be set (processor ports)
	localparam logic [5:0] REMAP_CAPABLE = 6'h30;
	localparam logic [2:0] M_CPU_INSTR = 3'h4;
	// per slave arbitration: set bit means fixed priority, else round robin
	localparam logic [5:0] ARB_FIXED = 6'h00;
	// ======================================================================
	// address map
	localparam logic [3:0] BANK_INTERNAL = 4'h0;
	localparam logic [3:0] BANK_EBI_FIRST = 4'h1;
	localparam logic [3:0] BANK_EBI_LAST = 4'h8;
	localparam logic [3:0] BANK_PERIPH = 4'hF;
	localparam logic [2:0] EBI_CS_MAX = 3'h5;
	localparam logic [7:0] REG_BOOT = 8'h00;
	localparam logic [7:0] REG_INSTRUCTION_COUPLED_RAM_AREA = 8'h01;
	localparam logic [7:0] REG_DATA_COUPLED_RAM_AREA = 8'h02;
	localparam logic [7:0] REG_SRAMC = 8'h03;
	localparam logic [7:0] REG_ROM = 8'h04;
	localparam logic [7:0] REG_LCD = 8'h05;
	localparam logic [7:0] REG_UDP = 8'h06;
	localparam logic [19:0] ROM_SIZE = 20'h08000;
	localparam logic [5:0] SRAM_UNITS = 6'h04;
	localparam logic [1:0] TCM_MAX_UNITS = 2'h2;
	localparam logic [1:0] TCM_RESET = 2'h0;
	localparam logic [1:0] BLK_ZERO = 2'h0;
	localparam logic [1:0] BLK_ONE = 2'h1;
	localparam logic [1:0] BLK_TWO = 2'h2;
	localparam logic [1:0] BLK_THREE = 2'h3;
	// third edge: the second sync flop holds the pin only from the second
	localparam logic [1:0] BOOT_SETTLE = 2'h3;
	localparam logic BOOT_ROM_RESET = 1'b1;
	// ======================================================================
	// types
	typedef struct packed {
		logic err;
		logic [2:0] slave;
		logic [31:0] addr;
		logic [1:0] block;
		logic [2:0] cs;
	} bmd_dec_s;
	typedef struct packed {
		logic [2:0] last;
	} bmd_arb_s;
endpackage

// ### core/bmd_arb.sv
// one slave arbiter: round robin or fixed priority over six masters
`timescale 1ns/1ps
module bmd_arb #(
	parameter logic FIXED = 1'b0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [5:0] req,
	output logic [5:0] gnt
);
	bmd_pkg::bmd_arb_s st;
	bmd_pkg::bmd_arb_s next_st;

	// ======================================================================
	// grant selection
	always_comb begin
		logic [2:0] idx;
		logic found;
		idx = 3'h0;
		found = 1'b0;
		gnt = 6'h00;
		next_st = st;
		for (int k = 1; k <= bmd_pkg::NUM_M; k++) begin
			// fixed scheme scans from master 5 down, so the cpu wins
			if (FIXED)
				idx = 3'(bmd_pkg::NUM_M - k);
			else
				idx = 3'((32'(st.last) + 32'(k)) % bmd_pkg::NUM_M);
			if (!found && req[idx]) begin
				found = 1'b1;
				gnt[idx] = 1'b1;
				next_st.last = idx;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			st <= '0;
		else
			st <= next_st;
	end
endmodule

// ### verification/bmd_master_model.sv
// master-side model: holds each request until the matrix takes it
`timescale 1ns/1ps
module bmd_master_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [2:0] idx,
	input wire logic [31:0] addr,
	input wire logic [5:0] m_ready,
	output logic [5:0] m_req,
	output logic [5:0][31:0] m_addr,
	output logic hit
);
	// ======================================================================
	// request hold and release
	initial begin
		m_req = 6'h00;
		m_addr = '0;
		hit = 1'b0;
	end
	always @(posedge clk) begin
		hit <= |(m_req & m_ready);
	end
	// released address lines show the inverse, never the stale value
	always @(negedge clk) begin
		if (hit) begin
			m_req <= 6'h00;
			m_addr[idx] <= ~m_addr[idx];
		end else if (go) begin
			m_req[idx] <= 1'b1;
			m_addr[idx] <= addr;
		end
	end
endmodule

// ### verification/bmd_matrix_properties.sv
// concurrent checks on the matrix ports
`timescale 1ns/1ps
module bmd_matrix_properties (
	input wire logic clk,
	input wire logic nrst,
	input wire logic boot_source_select_pin,
	input wire logic [5:0] m_req,
	input wire logic [5:0] m_ready,
	input wire logic [5:0] m_err,
	input wire logic [5:0] per_master_remap_set,
	input wire logic coupled_ram_size_wr,
	input wire logic [1:0] instruction_coupled_ram_area,
	input wire logic [1:0] data_coupled_ram_area,
	input wire logic [5:0] per_master_remap_bit,
	input wire logic [1:0] instr_units,
	input wire logic [1:0] data_units,
	input wire logic boot_from_rom,
	input wire logic [5:0] s_valid,
	input wire logic [5:0][2:0] s_master,
	input wire logic [2:0] external_chip_select_zero_idx
);
	// ======================================================================
	// edges since reset release, saturating
	logic [2:0] since_rst;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) since_rst <= 3'h0;
		else if (since_rst != 3'h7) since_rst <= since_rst + 3'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ======================================================================
	// assertions
	err_after_take_a: assert property (
		(m_err & ~$past(m_req & m_ready)) == 6'h00) else $error("stray err");
	valid_after_take_a: assert property (
		|s_valid |-> $past(|(m_req & m_ready))) else $error("stray valid");
	remap_low_a: assert property (
		per_master_remap_bit[3:0] == 4'h0) else $error("dma remap set");
	remap_set_a: assert property (
		per_master_remap_set[4] |=> per_master_remap_bit[4])
		else $error("remap not set");
	size_load_a: assert property (coupled_ram_size_wr &&
		instruction_coupled_ram_area != 2'h3 && data_coupled_ram_area != 2'h3
		|=> instr_units == $past(instruction_coupled_ram_area) &&
		data_units == $past(data_coupled_ram_area)) else $error("size load");
	size_hold_a: assert property (!coupled_ram_size_wr |=>
		$stable(instr_units) && $stable(data_units)) else $error("size drift");
	units_max_a: assert property (
		instr_units != 2'h3 && data_units != 2'h3) else $error("size range");
	boot_capture_a: assert property (since_rst == 3'h3 |->
		boot_from_rom == boot_source_select_pin) else $error("boot capture");
	boot_hold_a: assert property (
		since_rst >= 3'h4 |-> $stable(boot_from_rom)) else $error("boot drift");
	lcd_path_a: assert property (
		s_valid[2] |-> s_master[2] >= 3'h4) else $error("lcd path");
	rom_path_a: assert property (
		s_valid[0] |-> s_master[0] != 3'h2) else $error("rom path");
	bridge_path_a: assert property (
		s_valid[5] |-> s_master[5] <= 3'h2) else $error("bridge path");
	cs_range_a: assert property (
		s_valid[4] |-> external_chip_select_zero_idx <= 3'h5)
		else $error("cs range");
endmodule
bind bmd_matrix bmd_matrix_properties bmd_matrix_properties_i (.clk, .nrst,
	.boot_source_select_pin, .m_req, .m_ready, .m_err, .per_master_remap_set,
	.coupled_ram_size_wr, .instruction_coupled_ram_area,
	.data_coupled_ram_area, .per_master_remap_bit, .instr_units,
	.data_units, .boot_from_rom, .s_valid, .s_master,
	.external_chip_select_zero_idx);

// ### verification/bus_matrix_decode_remap_tb_top.sv
// self-checking bench for matrix decode, boot remap and sram split
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module bus_matrix_decode_remap_tb_top;
	logic clk = 1'b0, nrst = 1'b0, boot_source_select_pin = 1'b1;
	logic go = 1'b0, hit, coupled_ram_size_wr = 1'b0, boot_from_rom;
	logic [2:0] idx = 3'h0, external_chip_select_zero_idx;
	logic [31:0] addr = 32'h0;
	logic [5:0] per_master_remap_set = 6'h00, per_master_remap_clr = 6'h00;
	logic [5:0] m_req, m_ready, m_err, per_master_remap_bit, s_valid;
	logic [1:0] instruction_coupled_ram_area = 2'h0, instr_units, data_units;
	logic [1:0] data_coupled_ram_area = 2'h0, sram_block;
	logic [5:0][31:0] m_addr, s_addr;
	logic [5:0][2:0] s_master;
	int error_cnt = 0, check_count = 0, cyc = 0;
	// ======================================================================
	// clock, design, far side
	always #12.5 clk = ~clk;
	bmd_matrix bmd_matrix_i (.clk, .nrst, .boot_source_select_pin, .m_req,
		.m_addr, .m_ready, .m_err, .per_master_remap_set,
		.per_master_remap_clr, .coupled_ram_size_wr,
		.instruction_coupled_ram_area, .data_coupled_ram_area,
		.per_master_remap_bit, .instr_units, .data_units, .boot_from_rom,
		.s_valid, .s_master, .s_addr, .sram_block,
		.external_chip_select_zero_idx);
	bmd_master_model bmd_master_model_i (.clk, .go, .idx, .addr, .m_ready,
		.m_req, .m_addr, .hit);
	// ======================================================================
	// tasks
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// pin held steady from reset until well after capture
	task reset_dut(input logic p);
		@(negedge clk);
		nrst <= 1'b0;
		boot_source_select_pin <= p;
		repeat (3) @(negedge clk);
		nrst <= 1'b1;
		repeat (3) @(negedge clk);
	endtask
	// slave 7 means an error answer is expected
	task acc(input logic [2:0] m, input logic [31:0] a, input logic [2:0] s,
		input logic [2:0] x);
		int n;
		logic [31:0] ea;
		n = 0;
		// internal slaves see only the offset inside their 1 MB region of bank 0
		ea = (a[31:28] == 4'h0) ? {12'h000, a[19:0]} : a;
		@(negedge clk);
		go <= 1'b1;
		idx <= m;
		addr <= a;
		do begin
			@(negedge clk);
			n++;
		end while (hit !== 1'b1 && n < 10);
		go <= 1'b0;
		`CHK(hit, 1'b1)
		if (s == 3'h7) `CHK(m_err[m], 1'b1)
		else begin
			`CHK(s_valid[s], 1'b1)
			`CHK(s_master[s], m)
			`CHK(s_addr[s], ea)
			if (s == 3'h1) `CHK(sram_block, x[1:0])
			if (s == 3'h4) `CHK(external_chip_select_zero_idx, x)
		end
	endtask
	task pulse(input logic [5:0] st, input logic [5:0] cl, input logic w,
		input logic [1:0] i, input logic [1:0] d);
		@(negedge clk);
		per_master_remap_set <= st;
		per_master_remap_clr <= cl;
		coupled_ram_size_wr <= w;
		instruction_coupled_ram_area <= i;
		data_coupled_ram_area <= d;
		@(negedge clk);
		per_master_remap_set <= 6'h00;
		per_master_remap_clr <= 6'h00;
		coupled_ram_size_wr <= 1'b0;
		@(negedge clk);
	endtask
	// ======================================================================
	// timeout, then tests
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			complete_run;
		end
	end
	initial begin
		reset_dut(1'b1);
		`CHK(per_master_remap_bit, 6'h00)
		`CHK({instr_units, data_units}, 4'h0)
		`CHK(boot_from_rom, 1'b1)
		$display("test reset done");
		acc(3'h0, 32'h10000000, 3'h4, 3'h0);
		acc(3'h0, 32'h80000000, 3'h4, 3'h5);
		acc(3'h0, 32'h90000000, 3'h7, 3'h0);
		acc(3'h1, 32'hF0000000, 3'h5, 3'h0);
		acc(3'h3, 32'hF0000000, 3'h7, 3'h0);
		acc(3'h2, 32'h00400000, 3'h7, 3'h0);
		acc(3'h1, 32'h00500000, 3'h7, 3'h0);
		acc(3'h5, 32'h00600000, 3'h3, 3'h0);
		acc(3'h4, 32'h00500000, 3'h2, 3'h0);
		acc(3'h0, 32'h00400000, 3'h0, 3'h0);
		acc(3'h0, 32'h00000000, 3'h0, 3'h0);
		acc(3'h0, 32'h00300000, 3'h1, 3'h3);
		acc(3'h2, 32'h0030C000, 3'h1, 3'h0);
		acc(3'h0, 32'h00700000, 3'h7, 3'h0);
		acc(3'h0, 32'h00100000, 3'h7, 3'h0);
		$display("test decode done");
		pulse(6'h11, 6'h00, 1'b0, 2'h0, 2'h0);
		`CHK(per_master_remap_bit, 6'h10)
		acc(3'h4, 32'h00000000, 3'h1, 3'h3);
		acc(3'h0, 32'h00000000, 3'h0, 3'h0);
		acc(3'h5, 32'h00000000, 3'h0, 3'h0);
		pulse(6'h20, 6'h10, 1'b0, 2'h0, 2'h0);
		`CHK(per_master_remap_bit, 6'h20)
		pulse(6'h20, 6'h20, 1'b0, 2'h0, 2'h0);
		`CHK(per_master_remap_bit, 6'h20)
		$display("test remap done");
		pulse(6'h00, 6'h00, 1'b1, 2'h2, 2'h1);
		`CHK({instr_units, data_units}, 4'h9)
		acc(3'h5, 32'h00100000, 3'h1, 3'h1);
		acc(3'h0, 32'h00104000, 3'h1, 3'h0);
		acc(3'h1, 32'h00200000, 3'h1, 3'h3);
		acc(3'h0, 32'h00204000, 3'h7, 3'h0);
		acc(3'h0, 32'h00300000, 3'h1, 3'h2);
		acc(3'h0, 32'h00304000, 3'h7, 3'h0);
		acc(3'h5, 32'h00000000, 3'h1, 3'h2);
		acc(3'h4, 32'h00100000, 3'h7, 3'h0);
		pulse(6'h00, 6'h00, 1'b1, 2'h3, 2'h0);
		`CHK({instr_units, data_units}, 4'h9)
		$display("test split done");
		reset_dut(1'b0);
		`CHK(boot_from_rom, 1'b0)
		`CHK(per_master_remap_bit, 6'h00)
		acc(3'h0, 32'h00000000, 3'h4, 3'h0);
		acc(3'h3, 32'h00400000, 3'h0, 3'h0);
		$display("test external boot done");
		complete_run;
	end
endmodule
